// ### design/fcs_pkg.sv
// Package of constants and types for the flash command sequencer
package fcs_pkg;
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned PULSE_TIMING_CLOCK_MAX_HZ = 200000;
  localparam int unsigned PULSE_TIMING_CLOCK_MIN_HZ = 150000;
  localparam logic [10:0] DIV_MIN = 11'((CLK_HZ + PULSE_TIMING_CLOCK_MAX_HZ - 1) / PULSE_TIMING_CLOCK_MAX_HZ);
  localparam logic [10:0] DIV_MAX = 11'(CLK_HZ / PULSE_TIMING_CLOCK_MIN_HZ);
  localparam int unsigned ADR_W = 17;
  localparam logic [16:0] OFS_DIV = 17'h00000;
  localparam logic [16:0] OFS_STAT = 17'h00004;
  localparam logic [16:0] OFS_CMD = 17'h00008;
  localparam int unsigned ARRAY_BIT = 16;
  localparam logic [15:0] ARRAY_SPLIT = 16'h8000;
  localparam int unsigned PAGE_BITS = 9;
  localparam int unsigned ROW_BITS = 6;
  localparam int unsigned ST_CBEF = 7;
  localparam int unsigned ST_CCF = 6;
  localparam int unsigned ST_ACCERR = 4;
  localparam int unsigned ST_BLANK = 2;
  localparam int unsigned DIV_LD_BIT = 31;
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_PAGE = 8'h40;
  localparam logic [7:0] CMD_MASS = 8'h41;
  localparam logic [14:0] TICKS_BYTE = 15'h0009;
  localparam logic [14:0] TICKS_BURST = 15'h0004;
  localparam logic [14:0] TICKS_BLANK = 15'h0009;
  localparam int unsigned TICKS_PAGE = 4000;
  localparam int unsigned TICKS_MASS = 20000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ADDR, SEQ_CMD} fcs_seq_e;
  typedef enum logic {EX_IDLE, EX_RUN} fcs_exe_e;
endpackage : fcs_pkg

// ### design/fcs_top.sv
// Flash command sequencer with AXI4-Lite register slave
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module fcs_top import fcs_pkg::*; #(
  parameter int unsigned PAGE_TICKS = TICKS_PAGE,
  parameter int unsigned MASS_TICKS = TICKS_MASS
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [16:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [16:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic BLANK_IN,
  output logic HV_PROGRAM,
  output logic HV_ERASE,
  output logic HV_BLANKCHK,
  output logic [1:0] ARRAY_SEL,
  output logic [15:0] OP_ADDR,
  output logic [7:0] OP_DATA,
  output logic [1:0] FETCH_OK
);
  typedef struct packed {
    logic aw_got;
    logic [16:0] aw_adr;
    logic w_got;
    logic [15:0] w_dat;
    logic w_en;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [10:0] div;
    logic div_ld;
    logic acc_err;
    logic ccf;
    logic blank_ok;
    logic cbef;
    fcs_seq_e seq;
    logic [15:0] buf_adr;
    logic [7:0] buf_dat;
    logic [7:0] buf_cmd;
    fcs_exe_e exe;
    logic [7:0] ex_cmd;
    logic [15:0] ex_adr;
    logic [14:0] cnt;
    logic [10:0] tick_cnt;
    logic hv_prog;
    logic hv_ers;
    logic hv_blank;
    logic [1:0] arr_sel;
    logic [15:0] op_adr;
    logic [7:0] op_dat;
    logic [1:0] fetch_ok;
    logic awready;
    logic wready;
    logic arready;
  } fcs_state_s;

  fcs_state_s s_q, s_d;

  function automatic logic cmd_known(input logic [7:0] c);
    cmd_known = (c == CMD_BLANK) || (c == CMD_BYTE) || (c == CMD_BURST) ||
                (c == CMD_PAGE) || (c == CMD_MASS);
  endfunction : cmd_known

  function automatic logic both_arrays(input logic [7:0] c);
    both_arrays = (c == CMD_MASS) || (c == CMD_BLANK);
  endfunction : both_arrays

  // One-hot array select from address, both only for mass erase and blank check
  function automatic logic [1:0] sel_of(input logic [7:0] c, input logic [15:0] a);
    if (both_arrays(c)) begin
      sel_of = 2'h3;
    end else begin
      sel_of = (a >= ARRAY_SPLIT) ? 2'h1 : 2'h2;
    end
  endfunction : sel_of

  logic div_ok;
  logic tick;
  logic done;
  logic start;
  logic chain;
  logic wr_fire;
  logic rd_fire;
  logic wr_array;
  logic [15:0] wr_aa;

  assign div_ok = s_q.div_ld && (s_q.div >= DIV_MIN) && (s_q.div <= DIV_MAX);
  assign tick = div_ok && (s_q.tick_cnt == s_q.div - 11'h001);
  assign done = (s_q.exe == EX_RUN) && tick && (s_q.cnt == 15'h0001);
  assign chain = done && (s_q.ex_cmd == CMD_BURST) && (s_q.buf_cmd == CMD_BURST) &&
                 (s_q.buf_adr == s_q.ex_adr + 16'h0001) &&
                 (s_q.buf_adr[ROW_BITS-1:0] != '0);
  assign start = !s_q.cbef && ((s_q.exe == EX_IDLE) || done);
  assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign rd_fire = ARVALID && !s_q.rvalid;
  assign wr_array = s_q.aw_adr[ARRAY_BIT];
  assign wr_aa = s_q.aw_adr[15:0];

  always_comb begin
    s_d = s_q;
    // AXI write address and data are taken in either order
    if (AWVALID && !s_q.aw_got) begin
      s_d.aw_got = 1'b1;
      s_d.aw_adr = AWADDR;
    end
    if (WVALID && !s_q.w_got) begin
      s_d.w_got = 1'b1;
      s_d.w_dat = WDATA[15:0];
      s_d.w_en = WSTRB[0];
    end
    if (s_q.bvalid && BREADY) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && RREADY) begin
      s_d.rvalid = 1'b0;
    end
    // Timing clock divider
    if (div_ok) begin
      s_d.tick_cnt = tick ? 11'h000 : s_q.tick_cnt + 11'h001;
    end
    // Execution engine
    if (s_q.exe == EX_RUN && tick && !done) begin
      s_d.cnt = s_q.cnt - 15'h0001;
    end
    if (done) begin
      s_d.exe = EX_IDLE;
      s_d.hv_prog = 1'b0;
      s_d.hv_ers = 1'b0;
      s_d.hv_blank = 1'b0;
      s_d.fetch_ok = 2'h3;
      if (s_q.ex_cmd == CMD_BLANK) begin
        s_d.blank_ok = BLANK_IN;
      end
      if (s_q.cbef) begin
        s_d.ccf = 1'b1;
      end
    end
    if (start) begin
      s_d.exe = EX_RUN;
      s_d.cbef = 1'b1;
      s_d.ex_cmd = s_q.buf_cmd;
      s_d.ex_adr = s_q.buf_adr;
      s_d.tick_cnt = 11'h000;
      s_d.hv_prog = (s_q.buf_cmd == CMD_BYTE) || (s_q.buf_cmd == CMD_BURST);
      s_d.hv_ers = (s_q.buf_cmd == CMD_PAGE) || (s_q.buf_cmd == CMD_MASS);
      s_d.hv_blank = (s_q.buf_cmd == CMD_BLANK);
      s_d.arr_sel = sel_of(s_q.buf_cmd, s_q.buf_adr);
      s_d.fetch_ok = ~sel_of(s_q.buf_cmd, s_q.buf_adr);
      s_d.op_dat = s_q.buf_dat;
      s_d.op_adr = s_q.buf_adr;
      if (s_q.buf_cmd == CMD_PAGE) begin
        s_d.op_adr[PAGE_BITS-1:0] = '0;
      end
      if (s_q.buf_cmd == CMD_MASS) begin
        s_d.op_adr = '0;
      end
      if (both_arrays(s_q.buf_cmd) || s_q.buf_cmd == CMD_PAGE) begin
        s_d.op_dat = '0;
      end
      unique case (s_q.buf_cmd)
        CMD_BYTE: s_d.cnt = TICKS_BYTE;
        CMD_BURST: s_d.cnt = chain ? TICKS_BURST : TICKS_BYTE;
        CMD_PAGE: s_d.cnt = 15'(PAGE_TICKS);
        CMD_MASS: s_d.cnt = 15'(MASS_TICKS);
        default: s_d.cnt = TICKS_BLANK;
      endcase
    end
    // Register writes
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      if (!s_q.w_en) begin
        s_d.bresp = RESP_OKAY;
      end else if (wr_array) begin
        if (s_q.acc_err) begin
          s_d.seq = s_q.seq;
        end else if (!div_ok || !s_q.cbef || s_q.seq != SEQ_IDLE) begin
          s_d.acc_err = 1'b1;
          s_d.seq = SEQ_IDLE;
        end else begin
          s_d.seq = SEQ_ADDR;
          s_d.buf_adr = wr_aa;
          s_d.buf_dat = s_q.w_dat[7:0];
        end
      end else if (s_q.aw_adr == OFS_CMD) begin
        if (!s_q.acc_err) begin
          if (s_q.seq != SEQ_ADDR || !cmd_known(s_q.w_dat[7:0])) begin
            s_d.acc_err = 1'b1;
            s_d.seq = SEQ_IDLE;
          end else begin
            s_d.seq = SEQ_CMD;
            s_d.buf_cmd = s_q.w_dat[7:0];
          end
        end
      end else if (s_q.aw_adr == OFS_STAT) begin
        if (s_q.w_dat[ST_ACCERR]) begin
          s_d.acc_err = 1'b0;
        end
        if (s_q.seq == SEQ_CMD && s_q.w_dat[ST_CBEF]) begin
          s_d.cbef = 1'b0;
          s_d.ccf = 1'b0;
          s_d.seq = SEQ_IDLE;
        end else if (s_q.seq != SEQ_IDLE) begin
          s_d.acc_err = 1'b1;
          s_d.seq = SEQ_IDLE;
        end
      end else if (s_q.aw_adr == OFS_DIV) begin
        if (s_q.seq != SEQ_IDLE) begin
          s_d.acc_err = 1'b1;
          s_d.seq = SEQ_IDLE;
        end else if (!s_q.div_ld && !s_q.acc_err) begin
          s_d.div_ld = 1'b1;
          s_d.div = s_q.w_dat[10:0];
        end
      end else begin
        s_d.bresp = RESP_SLVERR;
      end
    end
    // Register reads
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = '0;
      if (ARADDR == OFS_DIV) begin
        s_d.rdata[10:0] = s_q.div;
        s_d.rdata[DIV_LD_BIT] = s_q.div_ld;
      end else if (ARADDR == OFS_STAT) begin
        s_d.rdata[ST_CBEF] = s_q.cbef;
        s_d.rdata[ST_CCF] = s_q.ccf;
        s_d.rdata[ST_ACCERR] = s_q.acc_err;
        s_d.rdata[ST_BLANK] = s_q.blank_ok;
      end else if (ARADDR == OFS_CMD) begin
        s_d.rdata[7:0] = s_q.buf_cmd;
      end else begin
        s_d.rresp = RESP_SLVERR;
      end
      if (s_q.seq == SEQ_CMD && !ARADDR[ARRAY_BIT] && s_d.rresp == RESP_OKAY) begin
        s_d.acc_err = 1'b1;
        s_d.seq = SEQ_IDLE;
      end
    end
    // Ready outputs kept in flops
    s_d.awready = !s_d.aw_got;
    s_d.wready = !s_d.w_got;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      s_q <= '0;
      s_q.cbef <= 1'b1;
      s_q.ccf <= 1'b1;
      s_q.seq <= SEQ_IDLE;
      s_q.exe <= EX_IDLE;
      s_q.fetch_ok <= 2'h3;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign AWREADY = s_q.awready;
  assign WREADY = s_q.wready;
  assign BVALID = s_q.bvalid;
  assign BRESP = s_q.bresp;
  assign ARREADY = s_q.arready;
  assign RVALID = s_q.rvalid;
  assign RDATA = s_q.rdata;
  assign RRESP = s_q.rresp;
  assign HV_PROGRAM = s_q.hv_prog;
  assign HV_ERASE = s_q.hv_ers;
  assign HV_BLANKCHK = s_q.hv_blank;
  assign ARRAY_SEL = s_q.arr_sel;
  assign OP_ADDR = s_q.op_adr;
  assign OP_DATA = s_q.op_dat;
  assign FETCH_OK = s_q.fetch_ok;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  AST_NO_RUN_WITHOUT_DIV: assert property (s_q.exe == EX_RUN |-> div_ok)
    else $error("Command running without a valid divider");
  AST_DIV_ONCE: assert property ($past(s_q.div_ld) |-> $stable(s_q.div))
    else $error("Divider changed after first write");
  AST_DIV_BLOCKED_BY_ERR: assert property (
    s_q.acc_err && !s_q.div_ld |=> !s_q.div_ld)
    else $error("Divider written while access error set");
  AST_LAUNCH_RUNS: assert property (
    wr_fire && s_q.w_en && s_q.aw_adr == OFS_STAT && s_q.seq == SEQ_CMD &&
    s_q.w_dat[ST_CBEF] && s_q.exe == EX_IDLE |=> !s_q.cbef && !s_q.ccf
    ##1 s_q.exe == EX_RUN && s_q.cbef)
    else $error("Launch did not start execution");
  AST_ABORT_ERR: assert property (
    wr_fire && s_q.w_en && s_q.aw_adr == OFS_STAT && s_q.seq != SEQ_IDLE &&
    !(s_q.seq == SEQ_CMD && s_q.w_dat[ST_CBEF]) |=> s_q.acc_err && s_q.seq == SEQ_IDLE)
    else $error("Abort did not raise access error");
  AST_BAD_CODE: assert property (
    wr_fire && s_q.w_en && s_q.aw_adr == OFS_CMD && !s_q.acc_err &&
    !cmd_known(s_q.w_dat[7:0]) |=> s_q.acc_err)
    else $error("Unknown command code accepted");
  AST_ONE_ARRAY: assert property (
    (s_q.hv_prog || (s_q.hv_ers && s_q.ex_cmd == CMD_PAGE)) |->
    $onehot(s_q.arr_sel) && (s_q.fetch_ok == ~s_q.arr_sel))
    else $error("Program or page erase on both arrays");
  AST_PAGE_ALIGN: assert property (
    s_q.hv_ers && s_q.ex_cmd == CMD_PAGE |-> s_q.op_adr[PAGE_BITS-1:0] == '0)
    else $error("Page erase address not page aligned");
  AST_BUSY_FLAG: assert property (s_q.exe == EX_RUN |-> !s_q.ccf)
    else $error("Complete flag high while running");
  AST_ERR_HOLDS: assert property (
    s_q.acc_err && !(wr_fire && s_q.aw_adr == OFS_STAT && s_q.w_dat[ST_ACCERR])
    |=> s_q.acc_err)
    else $error("Access error cleared without a one write");
  AST_TICK_ALIGN: assert property (start |=> s_q.tick_cnt == 11'h000)
    else $error("Timing count not restarted at command start");
  AST_CHAIN_SHORT: assert property (
    start && chain |=> s_q.cnt == TICKS_BURST)
    else $error("Chained burst byte not given the short time");
  AST_FULL_BUF_ERR: assert property (
    wr_fire && s_q.w_en && wr_array && !s_q.acc_err && !s_q.cbef |=> s_q.acc_err)
    else $error("Array write with full buffer accepted");

  COV_LAUNCH: cover property (start && s_q.buf_cmd == CMD_BYTE);
  COV_CHAIN: cover property (start && chain);
  COV_ABORT: cover property (s_q.seq != SEQ_IDLE ##1 s_q.acc_err);
  COV_MASS: cover property (start && s_q.buf_cmd == CMD_MASS);
  COV_QUEUED: cover property (s_q.exe == EX_RUN && !s_q.cbef);
endmodule : fcs_top

// ### test/fcs_tb_top.sv
// Self-checking testbench for the flash command sequencer
`timescale 1ns/1ps
module fcs_tb_top import fcs_pkg::*;;
  localparam int DIV = 1000;
  localparam int PT = 5;
  localparam int MT = 10;
  logic clock, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, blank_in, hv_p, hv_e, hv_b;
  logic [16:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, arr_sel, fetch_ok, rsp;
  logic [15:0] op_addr;
  logic [7:0] op_data;
  int fails, cmp_count;
  int cyc = 0;
  fcs_top #(.PAGE_TICKS(PT), .MASS_TICKS(MT)) u_dut (.CLOCK(clock), .RST(rst),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .BLANK_IN(blank_in), .HV_PROGRAM(hv_p),
    .HV_ERASE(hv_e), .HV_BLANKCHK(hv_b), .ARRAY_SEL(arr_sel), .OP_ADDR(op_addr),
    .OP_DATA(op_data), .FETCH_OK(fetch_ok));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      fails++;
      end_of_test();
    end
  endtask : tmo
  task automatic wr(input logic [16:0] a, input logic [31:0] d);
    int n;
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (bvalid === 1'b1) break;
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    rsp = bresp;
    if (n == 50) begin
      fails++;
      end_of_test();
    end
  endtask : wr
  task automatic rd(input logic [16:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd_v = rdata;
    rsp = rresp;
    if (n == 50) begin
      fails++;
      end_of_test();
    end
  endtask : rd
  task automatic st(input logic [31:0] exp);
    rd(OFS_STAT);
    chk(rd_v & 32'h000000D0, exp);
  endtask : st
  task automatic do_cmd(input logic [7:0] c, input logic [15:0] a, input int tk);
    logic [7:0] d;
    logic [1:0] s;
    logic [2:0] hv;
    int n, t0;
    d = 8'($urandom);
    blank_in <= 1'($urandom);
    s = (c == CMD_MASS || c == CMD_BLANK) ? 2'b11 : (a >= ARRAY_SPLIT ? 2'b01 : 2'b10);
    hv = (c == CMD_BLANK) ? 3'b001 : ((c == CMD_PAGE || c == CMD_MASS) ? 3'b010 : 3'b100);
    wr({1'b1, a}, {24'h000000, d});
    wr(OFS_CMD, {24'h000000, c});
    wr(OFS_STAT, 32'h00000080);
    for (n = 0; n < 20 && {hv_p, hv_e, hv_b} === 3'b000; n++) @(posedge clock);
    tmo(n, 20);
    t0 = cyc;
    chk({hv_p, hv_e, hv_b}, hv);
    chk(arr_sel, s);
    chk(fetch_ok, s ^ 2'b11);
    if (c == CMD_PAGE) chk(op_addr, a & 16'hFE00);
    if (c == CMD_MASS) chk(op_addr, 16'h0000);
    if (c == CMD_BYTE || c == CMD_BURST) chk({op_addr, op_data}, {a, d});
    else chk(op_data, 8'h00);
    rd(OFS_STAT);
    chk(rd_v & 32'h000000C0, 32'h00000080);
    for (n = 0; n < 30000 && {hv_p, hv_e, hv_b} !== 3'b000; n++) @(posedge clock);
    tmo(n, 30000);
    chk(cyc - t0, tk * DIV);
    chk(fetch_ok, 2'b11);
    rd(OFS_STAT);
    chk(rd_v & 32'h000000D0, 32'h000000C0);
    if (c == CMD_BLANK) chk(rd_v[ST_BLANK], blank_in);
  endtask : do_cmd
  initial begin
    logic [7:0] codes [5];
    int tks [5];
    int n, t0;
    codes = '{CMD_BYTE, CMD_BURST, CMD_PAGE, CMD_MASS, CMD_BLANK};
    tks = '{9, 9, PT, MT, 9};
    {awvalid, wvalid, arvalid, blank_in} = 4'h0;
    {awaddr, araddr, wdata} = '0;
    {bready, rready, rst} = 3'b111;
    wstrb = 4'hF;
    fails = 0;
    cmp_count = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    void'($urandom(40));
    st(32'h000000C0);
    wr({1'b1, 16'h9000}, 32'h00000055);
    st(32'h000000D0);
    wr(OFS_DIV, DIV);
    rd(OFS_DIV);
    chk(rd_v[DIV_LD_BIT], 1'b0);
    wr(OFS_STAT, 32'h00000000);
    st(32'h000000D0);
    wr(OFS_STAT, 32'h00000010);
    st(32'h000000C0);
    wr(OFS_DIV, DIV);
    wr(OFS_DIV, 1200);
    rd(OFS_DIV);
    chk(rd_v, 32'h80000000 | DIV);
    for (int i = 0; i < 5; i++) do_cmd(codes[i], {i[0], 15'($urandom)}, tks[i]);
    for (int k = 0; k < 5; k++) begin
      if (k != 2) wr({1'b1, 16'($urandom)}, 32'h000000A5);
      if (k == 0) wr(OFS_CMD, 32'h00000033);
      if (k == 1) wr(OFS_STAT, 32'h00000000);
      if (k == 2) wr(OFS_CMD, CMD_BYTE);
      if (k == 3) wr({1'b1, 16'h1234}, 32'h00000011);
      if (k == 4) wr(OFS_CMD, CMD_BYTE);
      if (k == 4) rd(OFS_DIV);
      st(32'h000000D0);
      wr({1'b1, 16'h2000}, 32'h00000001);
      wr(OFS_CMD, CMD_BYTE);
      wr(OFS_STAT, 32'h00000080);
      repeat (4) @(posedge clock);
      chk({hv_p, hv_e, hv_b}, 3'b000);
      wr(OFS_STAT, 32'h00000010);
      st(32'h000000C0);
    end
    // Burst queued behind a burst at the next address in the same row
    wr({1'b1, 16'h8100}, 32'h0000005A);
    wr(OFS_CMD, CMD_BURST);
    wr(OFS_STAT, 32'h00000080);
    for (n = 0; n < 20 && hv_p !== 1'b1; n++) @(posedge clock);
    tmo(n, 20);
    t0 = cyc;
    wr({1'b1, 16'h8101}, 32'h000000A5);
    wr(OFS_CMD, CMD_BURST);
    wr(OFS_STAT, 32'h00000080);
    st(32'h00000000);
    wr({1'b1, 16'h8102}, 32'h00000001);
    st(32'h00000010);
    for (n = 0; n < 30000 && hv_p !== 1'b0; n++) @(posedge clock);
    tmo(n, 30000);
    chk(cyc - t0, (9 + 4) * DIV);
    st(32'h000000D0);
    wr(OFS_STAT, 32'h00000010);
    st(32'h000000C0);
    rd({1'b1, 16'h4000});
    chk(rsp, RESP_SLVERR);
    wr(17'h0000C, 32'h00000000);
    chk(rsp, RESP_SLVERR);
    end_of_test();
  end
endmodule : fcs_tb_top
